// >>> include/fci_pkg.sv
// Behaviour
// - security bit set only by set-security command; only debug chip erase clears it; code also clears it on reset.
// - under security refuse protected fuse writes, fuse byte 2, erase-all-fuses; lock error; code refuses fuse bit commands only at page numbers 16 to 19.
// - command write needs key 0xa5; other keys start nothing.
// - key field of the command register always reads zero.
// - unused command code sets program error, interrupt if enabled.
// - command write while busy is discarded and sets program error.
// - command codes 0 to 12 decoded as listed operations.
// - codes 13, 14, 15 are user page write, erase, erased check.
// - page buffer write loads page number from written address, except in a cycle where a started command loads its own page.
// - page number field stores only valid page bits; higher bits read zero.
// - page number means page, region page, fuse index or fuse byte data and address.
// - status bit 0 shows ready; software waits for ready before next command.
// - lock error bit 2 set on locked region programming, cleared on status read; code sets it only on commands refused under security.
// - program error bit 3 set on bad command or key, cleared on status read.
// - status bit 4 shows security state.
// - status bit 5 shows quick check result, 1 when erased.
// - three-bit size code, 0 for 32 Kbytes up to 7 for 1024 Kbytes.
// - interrupts on ready, lock error, program error gated by control bits 0, 2, 3.
// - wait-state control bit selects zero or one read wait state.
// - lock status and fuse mirrors follow fuse state; unmapped bits read zero.
// - region lock status bit is 1 when its region is locked.
// - fuse mirror bit reads 0 for programmed fuse, 1 for erased fuse.
package fci_pkg;
	localparam logic [7:0] FCI_CTRL_OFS   = 8'h00;
	localparam logic [7:0] FCI_CMD_OFS    = 8'h04;
	localparam logic [7:0] FCI_STAT_OFS   = 8'h08;
	localparam logic [7:0] FCI_FUSE_HI_OFS = 8'h0c;
	localparam logic [7:0] FCI_FUSE_LO_OFS = 8'h10;
	localparam logic [7:0] FCI_KEY        = 8'ha5;
	localparam int FCI_KEY_POS    = 24;
	localparam int FCI_PAGE_NUMBER_FIELD_POS  = 8;
	localparam int FCI_RDY_BIT    = 0;
	localparam int FCI_LOCK_ERROR_FLAG_BIT  = 2;
	localparam int FCI_PROGRAM_ERROR_FLAG_BIT  = 3;
	localparam int FCI_SEC_BIT    = 4;
	localparam int FCI_QUICK_CHECK_RESULT_BIT   = 5;
	localparam int FCI_FWS_BIT    = 6;
	localparam int FCI_FSZ_POS    = 13;
	localparam int FCI_LOCK_POS   = 16;
	localparam int FCI_EXTERNAL_FETCH_LOCK_FUSE_FUSE  = 16;
	localparam int FCI_BOOTP_LO   = 17;
	localparam int FCI_BOOTP_HI   = 19;
	localparam logic [31:0] FCI_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] FCI_FUSE_RST = 32'hfc07_ffff;
	localparam logic [31:0] FCI_CTRL_MASK = 32'h0000_004d;
	localparam logic [31:0] FCI_FUSE_ERASED = 32'hffff_ffff;
	localparam int FCI_OP_NS      = 80;
	localparam int FCI_CLK_NS     = 8;
	localparam int FCI_OP_CYC     = (FCI_OP_NS + FCI_CLK_NS - 1) / FCI_CLK_NS;
	typedef enum logic [3:0] {
		FCI_NOP, FCI_WP, FCI_EP, FCI_CPB, FCI_LP, FCI_UP, FCI_EA, FCI_WRITE_FUSE_BIT_COMMAND_C,
		FCI_ERASE_FUSE_BIT_COMMAND_C, FCI_SSB_C, FCI_PFB_C, FCI_EAF_C, FCI_QPR_C, FCI_WUP_C,
		FCI_EUP_C, FCI_QUP_C
	} fci_cmd_t;
	typedef enum logic [0:0] {FCI_IDLE, FCI_BUSY} fci_state_t;
endpackage

// >>> core/fci_flash_if.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module fci_flash_if import fci_pkg::*; #(
	parameter int PAGE_BITS = 10,
	parameter logic [2:0] SIZE_CODE = 3'h5,
	parameter int OP_CYCLES = FCI_OP_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        pbuf_wr,
	input  wire logic [15:0] pbuf_page,
	input  wire logic        chip_erase,
	input  wire logic        quick_erased,
	output logic             flash_irq,
	output logic             flash_wait_state,
	output logic [31:0]      fuse_out
);
	logic [31:0] ctrl_q;
	logic [15:0] page_q;
	logic [31:0] fuse_q;
	logic        sec_q, rdy_q, lock_error_flag_q, program_error_flag_q, quick_check_result_q, rdy_ev_q;
	fci_state_t  st_q;
	fci_cmd_t    cur_q;
	logic [15:0] cnt_q;
	logic        pready_q, pslverr_q, irq_q, fws_q;
	logic [31:0] prdata_q;

	// bus phase decode
	logic acc, fin, wr, rd, cmd_wr, stat_rd, key_ok, known;
	fci_cmd_t  new_cmd;
	logic [15:0] new_page, page_mask;
	logic        prot_hit, fuse_bit_cmd, lock_refuse, start;
	assign acc     = psel && penable && !pready_q;
	assign fin     = psel && penable && pready_q; // completing edge: writes and clears
	assign wr      = fin && pwrite;
	assign rd      = acc && !pwrite;
	assign cmd_wr  = wr && paddr == FCI_CMD_OFS;
	assign stat_rd = fin && !pwrite && paddr == FCI_STAT_OFS;
	assign key_ok  = pwdata[FCI_KEY_POS +: 8] == FCI_KEY;
	assign new_cmd = fci_cmd_t'(pwdata[3:0]);
	assign known   = pwdata[5:4] == 2'h0;
	assign page_mask = 16'((32'h1 << PAGE_BITS) - 32'h1);
	assign new_page  = pwdata[FCI_PAGE_NUMBER_FIELD_POS +: 16] & page_mask;
	assign fuse_bit_cmd = new_cmd == FCI_WRITE_FUSE_BIT_COMMAND_C || new_cmd == FCI_ERASE_FUSE_BIT_COMMAND_C;
	// protected fuses: external fetch lock and boot protect
	assign prot_hit = fuse_bit_cmd && new_page >= 16'(FCI_EXTERNAL_FETCH_LOCK_FUSE_FUSE)
		&& new_page <= 16'(FCI_BOOTP_HI);
	assign lock_refuse = sec_q && (prot_hit || new_cmd == FCI_EAF_C
		|| (new_cmd == FCI_PFB_C && new_page[2:0] == 3'h2));
	assign start = cmd_wr && key_ok && known && st_q == FCI_IDLE && !lock_refuse;

	// apb answer: one wait state, registered read data
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else begin
			pready_q  <= acc;
			pslverr_q <= 1'b0;
			if (rd) begin
				if (paddr == FCI_CTRL_OFS) begin
					prdata_q <= ctrl_q;
				end else if (paddr == FCI_CMD_OFS) begin
					prdata_q <= {8'h0, page_q, 4'h0, cur_q};
				end else if (paddr == FCI_STAT_OFS) begin
					prdata_q <= {fuse_q[15:0] ^ 16'hffff, SIZE_CODE, 7'h0,
						quick_check_result_q, sec_q, program_error_flag_q, lock_error_flag_q, 1'b0, rdy_q};
				end else if (paddr == FCI_FUSE_HI_OFS) begin
					prdata_q <= 32'h0;
				end else if (paddr == FCI_FUSE_LO_OFS) begin
					prdata_q <= fuse_q;
				end else begin
					prdata_q  <= 32'h0;
					pslverr_q <= 1'b1;
				end
			end else if (acc && pwrite) begin
				pslverr_q <= !(paddr == FCI_CTRL_OFS || paddr == FCI_CMD_OFS
					|| paddr == FCI_STAT_OFS);
			end
		end
	end

	// control register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl_q <= FCI_CTRL_RST;
		end else if (wr && paddr == FCI_CTRL_OFS) begin
			ctrl_q <= pwdata & FCI_CTRL_MASK;
		end
	end

	// command register and page number field
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			page_q <= 16'h0;
			cur_q  <= FCI_NOP;
		end else if (start) begin
			page_q <= new_page;
			cur_q  <= new_cmd;
		end else if (pbuf_wr) begin
			page_q <= pbuf_page & page_mask;
		end
	end

	// command engine
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_q     <= FCI_IDLE;
			cnt_q    <= 16'h0;
			rdy_q    <= 1'b1;
			rdy_ev_q <= 1'b0;
		end else begin
			rdy_ev_q <= 1'b0;
			case (st_q)
				FCI_IDLE: begin
					if (start) begin
						st_q  <= FCI_BUSY;
						rdy_q <= 1'b0;
						cnt_q <= 16'(OP_CYCLES - 1);
					end
				end
				FCI_BUSY: begin
					if (cnt_q == 16'h0) begin
						st_q     <= FCI_IDLE;
						rdy_q    <= 1'b1;
						rdy_ev_q <= 1'b1;
					end else begin
						cnt_q <= cnt_q - 16'h1;
					end
				end
				default: st_q <= FCI_IDLE;
			endcase
		end
	end

	// fuse array state, applied at command completion or on chip erase
	logic done;
	assign done = st_q == FCI_BUSY && cnt_q == 16'h0;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fuse_q <= FCI_FUSE_RST;
			sec_q  <= 1'b0;
			quick_check_result_q <= 1'b0;
		end else if (chip_erase) begin
			fuse_q <= FCI_FUSE_ERASED;
			sec_q  <= 1'b0;
		end else if (done) begin
			case (cur_q)
				FCI_LP: fuse_q[page_q[PAGE_BITS-1 -: 4]] <= 1'b0;
				FCI_UP: fuse_q[page_q[PAGE_BITS-1 -: 4]] <= 1'b1;
				FCI_WRITE_FUSE_BIT_COMMAND_C: fuse_q[page_q[4:0]] <= 1'b0;
				FCI_ERASE_FUSE_BIT_COMMAND_C: fuse_q[page_q[4:0]] <= 1'b1;
				FCI_PFB_C: if (page_q[2:0] < 3'h4) begin
					fuse_q[{page_q[1:0], 3'h0} +: 8] <= page_q[10:3];
				end
				FCI_EAF_C: fuse_q <= FCI_FUSE_ERASED;
				FCI_SSB_C: sec_q <= 1'b1;
				FCI_QPR_C, FCI_QUP_C: quick_check_result_q <= quick_erased;
				default: ;
			endcase
		end
	end

	// sticky error flags, set wins over read clear
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lock_error_flag_q <= 1'b0;
			program_error_flag_q <= 1'b0;
		end else begin
			if (cmd_wr && key_ok && known && st_q == FCI_IDLE && lock_refuse) begin
				lock_error_flag_q <= 1'b1;
			end else if (stat_rd) begin
				lock_error_flag_q <= 1'b0;
			end
			if (cmd_wr && (!key_ok || !known || st_q != FCI_IDLE)) begin
				program_error_flag_q <= 1'b1;
			end else if (stat_rd) begin
				program_error_flag_q <= 1'b0;
			end
		end
	end

	// interrupt and wait-state outputs
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
			fws_q <= 1'b0;
		end else begin
			irq_q <= (ctrl_q[FCI_RDY_BIT] && rdy_q) || (ctrl_q[FCI_LOCK_ERROR_FLAG_BIT] && lock_error_flag_q)
				|| (ctrl_q[FCI_PROGRAM_ERROR_FLAG_BIT] && program_error_flag_q);
			fws_q <= ctrl_q[FCI_FWS_BIT];
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign flash_irq = irq_q;
	assign flash_wait_state = fws_q;
	assign fuse_out = fuse_q;

	// assertions
	sequence bad_write_s;
		cmd_wr && !key_ok;
	endsequence
	bad_key_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		bad_write_s |=> rdy_q == $past(rdy_q) && program_error_flag_q)
		else $error("bad key changed ready");
	busy_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(cmd_wr && st_q == FCI_BUSY && cnt_q != 16'h0) |=> program_error_flag_q && st_q == FCI_BUSY)
		else $error("busy write not flagged");
	sec_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(sec_q && !chip_erase) |=> sec_q)
		else $error("security cleared");
	refuse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(cmd_wr && key_ok && known && st_q == FCI_IDLE && lock_refuse) |=> lock_error_flag_q && rdy_q)
		else $error("protected command not refused");
	ready_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		start |=> !rdy_q [*2])
		else $error("ready not dropped");
	key_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rd && paddr == FCI_CMD_OFS) |=> prdata_q[31:24] == 8'h0)
		else $error("key read nonzero");
	page_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(page_q & ~page_mask) == 16'h0)
		else $error("page bits above range");
	irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ctrl_q[3:0] == 4'h0) |=> !irq_q)
		else $error("interrupt while disabled");
	status_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(stat_rd && !cmd_wr) |=> !lock_error_flag_q && !program_error_flag_q)
		else $error("flags not cleared by read");

	// busy length counter, only watched by assertions
	logic [15:0] busy_len_q;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			busy_len_q <= 16'h0;
		end else if (st_q == FCI_BUSY) begin
			busy_len_q <= busy_len_q + 16'h1;
		end else begin
			busy_len_q <= 16'h0;
		end
	end

	// named steps of a status read and a completion
	sequence stat_read_s;
		rd && paddr == FCI_STAT_OFS;
	endsequence
	sequence done_s;
		done;
	endsequence

	// bus answer shape
	pready_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		pready_q |=> !pready_q)
		else $error("pready longer than one cycle");

	pready_resp_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		acc |=> pready_q)
		else $error("access not answered");

	slverr_ready_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		pslverr_q |-> pready_q)
		else $error("pslverr without pready");

	unmapped_rd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rd && paddr > FCI_FUSE_LO_OFS) |=> pslverr_q && prdata_q == 32'h0)
		else $error("unmapped read not refused");

	// read data contents
	fuse_hi_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rd && paddr == FCI_FUSE_HI_OFS) |=> prdata_q == 32'h0)
		else $error("unmapped fuse word nonzero");

	fuse_lo_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rd && paddr == FCI_FUSE_LO_OFS) |=> prdata_q == $past(fuse_q))
		else $error("fuse mirror mismatch");

	stat_ready_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		stat_read_s |=> prdata_q[0] == $past(rdy_q))
		else $error("ready bit mismatch");

	stat_sec_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		stat_read_s |=> prdata_q[4] == $past(sec_q))
		else $error("security bit mismatch");

	stat_size_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		stat_read_s |=> prdata_q[15:13] == SIZE_CODE)
		else $error("size code mismatch");

	stat_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		stat_read_s |=> prdata_q[31:16] == ~$past(fuse_q[15:0]))
		else $error("lock status mismatch");

	stat_quick_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		stat_read_s |=> prdata_q[5] == $past(quick_check_result_q))
		else $error("quick result bit mismatch");

	// control register and its outputs
	ctrl_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ctrl_q & ~FCI_CTRL_MASK) == 32'h0)
		else $error("unused control bits set");

	fws_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fws_q == $past(ctrl_q[FCI_FWS_BIT]))
		else $error("wait state not following control");

	irq_ready_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ctrl_q[FCI_RDY_BIT] && rdy_q) |=> irq_q)
		else $error("ready interrupt missing");

	irq_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ctrl_q[FCI_LOCK_ERROR_FLAG_BIT] && lock_error_flag_q) |=> irq_q)
		else $error("lock error interrupt missing");

	irq_prog_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ctrl_q[FCI_PROGRAM_ERROR_FLAG_BIT] && program_error_flag_q) |=> irq_q)
		else $error("program error interrupt missing");

	// command acceptance and refusal
	busy_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(cmd_wr && st_q == FCI_BUSY) |=> $stable(cur_q))
		else $error("busy write changed command");

	unused_code_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(cmd_wr && key_ok && !known) |=> program_error_flag_q && $stable(cur_q))
		else $error("unused code acted upon");

	refuse_fuse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(cmd_wr && lock_refuse && st_q == FCI_IDLE && !chip_erase) |=> $stable(fuse_q))
		else $error("refused command altered fuses");

	// security bit life
	sec_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(done && cur_q == FCI_SSB_C && !chip_erase) |=> sec_q)
		else $error("security not set");

	sec_rise_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(sec_q) |-> $past(done && cur_q == FCI_SSB_C))
		else $error("security set without command");

	erase_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		chip_erase |=> !sec_q && fuse_q == FCI_FUSE_ERASED)
		else $error("chip erase incomplete");

	// completion and its timing
	ready_back_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		done_s |=> rdy_q && rdy_ev_q)
		else $error("ready not restored");

	busy_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		busy_len_q <= 16'(OP_CYCLES))
		else $error("command overran");

	done_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		done_s |-> busy_len_q == 16'(OP_CYCLES - 1))
		else $error("command length wrong");

	quick_res_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(done && (cur_q == FCI_QPR_C || cur_q == FCI_QUP_C)) |=> quick_check_result_q == $past(quick_erased))
		else $error("quick result not captured");

	lock_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(done && cur_q == FCI_LP && !chip_erase) |=> !fuse_q[$past(page_q[PAGE_BITS-1 -: 4])])
		else $error("region not locked");

	fuse_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(done && cur_q == FCI_WRITE_FUSE_BIT_COMMAND_C && !chip_erase) |=> !fuse_q[$past(page_q[4:0])])
		else $error("fuse bit not written");
endmodule
`default_nettype wire

// >>> verification/tb_flash_command_status_interface.sv
`timescale 1ns/1ns
`default_nettype none
module tb_flash_command_status_interface import fci_pkg::*;;
	logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic        pbuf_wr = 0, chip_erase = 0, quick_erased = 0, e;
	logic        pready, pslverr, flash_irq, flash_wait_state;
	logic [7:0]  paddr = 0, k;
	logic [15:0] pbuf_page = 0, locks = 0, p;
	logic [31:0] pwdata = 0, prdata, fuse_out, r, f;
	logic [5:0]  codes [8] = '{1, 2, 3, 6, 13, 14, 12, 15};
	logic [5:0]  bad_c [4] = '{7, 8, 10, 11};
	logic [15:0] bad_p [4] = '{17, 16, 2, 0};
	int          miscompares = 0, check_count = 0, i;
	always #4 sys_clk = ~sys_clk;
	fci_flash_if #(.PAGE_BITS(10), .SIZE_CODE(3'h5), .OP_CYCLES(10)) uut (.sys_clk(sys_clk),
		.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pbuf_wr(pbuf_wr), .pbuf_page(pbuf_page), .chip_erase(chip_erase),
		.quick_erased(quick_erased), .flash_irq(flash_irq),
		.flash_wait_state(flash_wait_state), .fuse_out(fuse_out));
	// verdict and end of run
	task automatic complete_run;
		$display("miscompares %0d checks %0d", miscompares, check_count);
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: want %h got %h", $time, exp, got);
		end
	endtask
	// one apb transfer, request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) miscompares++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic cmd(input logic [7:0] key, input logic [15:0] pg, input logic [5:0] c);
		apb(1'b1, FCI_CMD_OFS, {key, pg, 2'b00, c});
	endtask
	// poll status until ready, bounded
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			rd(FCI_STAT_OFS);
			n++;
		end while (r[0] !== 1'b1 && n < 40);
	endtask
	// hang guard
	initial begin
		#100000;
		miscompares++;
		complete_run;
	end
	initial begin
		void'($urandom(32'he4f6));
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(FCI_CTRL_OFS);
		chk(32'h0, r);
		rd(FCI_STAT_OFS);
		chk(32'h0000a001, r);
		rd(FCI_FUSE_LO_OFS);
		chk(FCI_FUSE_RST, r);
		rd(FCI_FUSE_HI_OFS);
		chk(32'h0, r);
		rd(8'h14);
		chk(32'h1, {r[30:0], e});
		apb(1'b1, FCI_CTRL_OFS, 32'h4d);
		rd(FCI_CTRL_OFS);
		chk(32'h4d, r);
		chk(32'h3, {30'h0, flash_wait_state, flash_irq});
		apb(1'b1, FCI_CTRL_OFS, 32'h08);
		repeat (2) @(posedge sys_clk);
		chk(32'h0, {31'h0, flash_irq});
		k = 8'($urandom);
		if (k == FCI_KEY) k = 8'h00;
		cmd(k, 16'h0040, 6'd4);
		rd(FCI_CMD_OFS);
		chk(32'h0, r);
		chk(32'h1, {31'h0, flash_irq});
		rd(FCI_STAT_OFS);
		chk(32'h0000a009, r);
		rd(FCI_STAT_OFS);
		chk(32'h0000a001, r);
		cmd(FCI_KEY, 16'h0, 6'(16 + $urandom % 48));
		rd(FCI_STAT_OFS);
		chk(32'h0000a009, r);
		cmd(FCI_KEY, 16'hffff, 6'd0);
		wait_rdy;
		rd(FCI_CMD_OFS);
		chk(32'h0003ff00, r);
		p = 16'($urandom);
		@(posedge sys_clk);
		pbuf_page <= p;
		pbuf_wr <= 1'b1;
		@(posedge sys_clk);
		pbuf_wr <= 1'b0;
		rd(FCI_CMD_OFS);
		chk({8'h0, p & 16'h03ff, 8'h0}, r);
		for (i = 0; i < 8; i++) begin
			quick_erased <= (codes[i] == 6'd12);
			cmd(FCI_KEY, 16'h0200, codes[i]);
			rd(FCI_STAT_OFS);
			if (codes[i] != 6'd6) chk(32'h0, {31'h0, r[0]});
			wait_rdy;
			if (codes[i] >= 6'd12) chk({31'h0, codes[i] == 6'd12}, {31'h0, r[5]});
		end
		for (i = 0; i < 3; i++) begin
			p = 16'($urandom) & 16'h03ff;
			cmd(FCI_KEY, p, 6'd4);
			cmd(FCI_KEY, p, 6'd5);
			rd(FCI_STAT_OFS);
			chk(32'h8, r & 32'h9);
			wait_rdy;
			locks[p[9:6]] = 1'b1;
			chk({locks, 16'ha001}, r & 32'hffffffdf);
			chk({16'h0, ~locks}, {16'h0, fuse_out[15:0]});
		end
		cmd(FCI_KEY, 16'h0, 6'd9);
		wait_rdy;
		chk(32'h10, r & 32'h10);
		f = fuse_out;
		for (i = 0; i < 4; i++) begin
			cmd(FCI_KEY, bad_p[i], bad_c[i]);
			rd(FCI_STAT_OFS);
			chk(32'h15, r & 32'h1d);
			chk(f, fuse_out);
		end
		rd(FCI_STAT_OFS);
		chk(32'h11, r & 32'h1d);
		cmd(FCI_KEY, 16'd20, 6'd7);
		wait_rdy;
		chk(32'h0, {31'h0, fuse_out[20]});
		@(posedge sys_clk);
		chip_erase <= 1'b1;
		@(posedge sys_clk);
		chip_erase <= 1'b0;
		rd(FCI_STAT_OFS);
		chk(32'h0, r & 32'h10);
		chk(32'hffffffff, fuse_out);
		cmd(FCI_KEY, 16'h0090, 6'd10);
		wait_rdy;
		chk(32'h12, fuse_out & 32'hff);
		complete_run;
	end
endmodule
`default_nettype wire
